// [csp_params.svh]
// Constants for the codec serial port block: offsets, field positions, reset values, timing.
// Assumes inclusion by bare name from every design file that needs them.
//
// What this block does
// - Mixed mode: top bit of each 16-bit input frame flags sample or control word.
// - Mixed-mode sample: 15 payload bits go to the upper DAC bits, LSB forced zero.
// - Mixed mode is on when mixed and data/program bits of main register are both one.
// - Mixed mode clears the MSB of every ADC sample sent out.
// - Mixed mode may be entered by the first control word, no prior program setup.
// - Digital loop-back copies each ADC sample into the DAC register; serial port keeps working.
// - Digital loop-back clears by control write only in mixed mode, else reset needed.
// - Serial-port loop-back echoes each word and frame sync 16 serial clocks later.
// - Serial-port loop-back clears by control write only in mixed mode, else reset needed.
// - Bit 7 of the analog config register routes DAC output to ADC input.
// - Analog loop-back only while gain tap power bit 1 of power register is zero.
// - Frame syncs high one serial clock before first bit, or during last bit if continuous.
// - Device drives the serial clock, which paces host transmit and receive.
// - A cascade holds at most eight units; dual device counts as two.
// - Output word completes 18 serial clocks after the sampling event.
// - Received data words are counted against the 3-bit cascade count field to load DAC.
// - Write control word with address zero is taken, read ignored; nonzero address decremented and passed on.
// - Program mode treats every received frame as a control word.
// - Hardware or software reset clears all control registers to zero.
`ifndef CSP_PARAMS_SVH
`define CSP_PARAMS_SVH

`define CSP_OFF_CTRL_LAST  8'h1C
`define CSP_OFF_STATUS     8'h20
`define CSP_OFF_ADC        8'h24
`define CSP_OFF_DAC        8'h28

`define CSP_REG_MAIN       3'h0
`define CSP_REG_POWER      3'h2
`define CSP_REG_ANALOG     3'h5

`define CSP_BIT_DP         0
`define CSP_BIT_MM         1
`define CSP_BIT_SLB        2
`define CSP_BIT_DLB        3
`define CSP_DC_HI          6
`define CSP_DC_LO          4
`define CSP_BIT_SWRST      7
`define CSP_BIT_GAINTAP    1
`define CSP_BIT_ALB        7

`define CSP_CW_FLAG        15
`define CSP_CW_READ        14
`define CSP_CW_ADDR_HI     13
`define CSP_CW_ADDR_LO     11

`define CSP_CTRL_RESET     8'h00
`define CSP_WORD_BITS      16
`define CSP_LOOP_SCLKS     16
`define CSP_MCLK_HZ        50000000
`define CSP_SCLK_HZ        6250000
`define CSP_SCLK_HALF      (`CSP_MCLK_HZ / (2 * `CSP_SCLK_HZ))
`define CSP_SAMPLE_SCLKS   256

`endif

// [csp_pkg.sv]
// Types shared by the codec serial port design files.
// Assumes nothing beyond a SystemVerilog compiler.
package csp_pkg;

  typedef enum logic [0:0] {
    RX_IDLE  = 1'b0,
    RX_SHIFT = 1'b1
  } csp_rx_state_type;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_SYNC  = 2'b01,
    TX_SHIFT = 2'b10
  } csp_tx_state_type;

endpackage

// [csp_ctrl_regs.sv]
// Small control register store with registered read data.
// Assumes one clock; clr wins over a write in the same cycle.
`timescale 1ns/1ps
`include "csp_params.svh"
module csp_ctrl_regs #(
  parameter int AW = 3,
  parameter int DW = 8
) (
  input  wire logic          clk,
  input  wire logic          clr,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata
);
  if (AW < 1 || DW < 8) begin : g_bad
    $error("csp_ctrl_regs: unsupported size");
  end

  logic [DW-1:0] mem_r [2**AW];

  always_ff @(posedge clk) begin
    if (clr) begin
      for (int i = 0; i < 2**AW; i++) begin
        mem_r[i] <= DW'(`CSP_CTRL_RESET);
      end
      rdata <= '0;
    end else begin
      if (we) begin
        mem_r[waddr] <= wdata;
      end
      rdata <= mem_r[raddr];
    end
  end
endmodule

// [csp_serial_port.sv]
// Codec serial port: frame handling, modes, loop-backs, cascade counting, AXI4-Lite view.
// Assumes host pins are asynchronous to mclk; AXI master runs on mclk.
`timescale 1ns/1ps
`include "csp_params.svh"
module csp_serial_port
  import csp_pkg::*;
#(
  parameter int SCLK_HALF    = `CSP_SCLK_HALF,
  parameter int SAMPLE_SCLKS = `CSP_SAMPLE_SCLKS
) (
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  output logic             serialClock,
  input  wire logic        serialDataIn,
  input  wire logic        inputFrameSync,
  output logic             serialDataOut,
  output logic             outputFrameSync,
  output logic [15:0]      dacData,
  output logic             analogLoopbackOn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  if (SCLK_HALF < 2 || SCLK_HALF > 256 || SAMPLE_SCLKS < 34 || SAMPLE_SCLKS > 65536) begin : g_bad
    $error("csp_serial_port: unsupported divider settings");
  end

  // Serial clock: divided from mclk, so pins are sampled at known edges
  logic [7:0] halfCnt_r;
  logic       sclk_r;
  wire        halfEnd = (halfCnt_r == 8'(SCLK_HALF - 1));
  wire        riseEn  = halfEnd && !sclk_r;
  wire        fallEn  = halfEnd && sclk_r;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      halfCnt_r <= 8'h00;
      sclk_r    <= 1'b0;
    end else begin
      halfCnt_r <= halfEnd ? 8'h00 : halfCnt_r + 8'h01;
      if (halfEnd) begin
        sclk_r <= !sclk_r;
      end
    end
  end
  assign serialClock = sclk_r;

  logic [1:0] sdiSync_r;
  logic [1:0] ifsSync_r;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sdiSync_r <= 2'b00;
      ifsSync_r <= 2'b00;
    end else begin
      sdiSync_r <= {sdiSync_r[0], serialDataIn};
      ifsSync_r <= {ifsSync_r[0], inputFrameSync};
    end
  end
  wire sdiBit = sdiSync_r[1];
  wire ifsBit = ifsSync_r[1];

  // Control state
  logic [7:0] ctrlMain_r;
  logic [7:0] ctrlPower_r;
  logic [7:0] ctrlAnalog_r;
  wire        dataSel    = ctrlMain_r[`CSP_BIT_DP];
  wire        mixedSel   = dataSel && ctrlMain_r[`CSP_BIT_MM];
  wire        slbOn      = ctrlMain_r[`CSP_BIT_SLB];
  wire        dlbOn      = ctrlMain_r[`CSP_BIT_DLB];
  wire [2:0]  cascadeCnt = ctrlMain_r[`CSP_DC_HI:`CSP_DC_LO];

  // Receiver
  csp_rx_state_type rxState_r;
  logic [15:0]      rxSr_r;
  logic [3:0]       rxBit_r;
  logic             rxDone_r;
  logic [15:0]      rxWord_r;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rxState_r <= RX_IDLE;
      rxSr_r    <= 16'h0000;
      rxBit_r   <= 4'h0;
      rxDone_r  <= 1'b0;
      rxWord_r  <= 16'h0000;
    end else begin
      rxDone_r <= 1'b0;
      if (fallEn) begin
        unique case (rxState_r)
          RX_IDLE: begin
            if (ifsBit) begin
              rxState_r <= RX_SHIFT;
              rxBit_r   <= 4'h0;
            end
          end
          RX_SHIFT: begin
            rxSr_r  <= {rxSr_r[14:0], sdiBit};
            rxBit_r <= rxBit_r + 4'h1;
            if (rxBit_r == 4'hF) begin
              rxDone_r <= 1'b1;
              rxWord_r <= {rxSr_r[14:0], sdiBit};
              // Sync during the last bit chains the next word directly
              if (!ifsBit) begin
                rxState_r <= RX_IDLE;
              end
            end
          end
        endcase
      end
    end
  end

  // Word decode
  wire       isCtrl   = !dataSel || (mixedSel && rxWord_r[`CSP_CW_FLAG]);
  wire [2:0] cwAddr   = rxWord_r[`CSP_CW_ADDR_HI:`CSP_CW_ADDR_LO];
  wire [2:0] cwReg    = rxWord_r[10:8];
  wire [7:0] cwData   = rxWord_r[7:0];
  wire       ctrlHere = rxDone_r && isCtrl && (cwAddr == 3'h0) && !rxWord_r[`CSP_CW_READ];
  wire       ctrlPass = rxDone_r && isCtrl && (cwAddr != 3'h0);
  wire       dataWord = rxDone_r && !isCtrl;
  wire       swReset  = ctrlHere && (cwReg == `CSP_REG_MAIN) && cwData[`CSP_BIT_SWRST];
  wire       regClr   = sys_rst || swReset;

  // Loop-back modes stay latched unless mixed mode is running
  function automatic logic [7:0] keepSticky(input logic [7:0] cur, input logic [7:0] nw);
    keepSticky = nw;
    if (!(cur[`CSP_BIT_DP] && cur[`CSP_BIT_MM])) begin
      keepSticky[`CSP_BIT_DLB] = nw[`CSP_BIT_DLB] | cur[`CSP_BIT_DLB];
      keepSticky[`CSP_BIT_SLB] = nw[`CSP_BIT_SLB] | cur[`CSP_BIT_SLB];
    end
  endfunction

  wire [7:0] ctrlWdata = (cwReg == `CSP_REG_MAIN) ? keepSticky(ctrlMain_r, cwData) : cwData;

  always_ff @(posedge mclk) begin
    if (regClr) begin
      ctrlMain_r   <= `CSP_CTRL_RESET;
      ctrlPower_r  <= `CSP_CTRL_RESET;
      ctrlAnalog_r <= `CSP_CTRL_RESET;
    end else if (ctrlHere) begin
      case (cwReg)
        `CSP_REG_MAIN:   ctrlMain_r   <= ctrlWdata;
        `CSP_REG_POWER:  ctrlPower_r  <= ctrlWdata;
        `CSP_REG_ANALOG: ctrlAnalog_r <= ctrlWdata;
        default: ;
      endcase
    end
  end

  logic analogLoop_r;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      analogLoop_r <= 1'b0;
    end else begin
      analogLoop_r <= ctrlAnalog_r[`CSP_BIT_ALB] && !ctrlPower_r[`CSP_BIT_GAINTAP];
    end
  end
  assign analogLoopbackOn = analogLoop_r;

  // Sample timer and transmit arbitration
  logic [15:0] sampleCnt_r;
  logic        sampleDue_r;
  logic [15:0] adcSample_r;
  logic        passPend_r;
  logic [15:0] passWord_r;
  csp_tx_state_type txState_r;
  logic [15:0] txSr_r;
  logic [3:0]  txBit_r;
  logic        outFs_r;
  logic        outData_r;

  wire        sampleTick   = riseEn && (sampleCnt_r == 16'(SAMPLE_SCLKS - 1));
  wire        txJob        = sampleDue_r || passPend_r;
  wire        txFree       = (txState_r == TX_IDLE) || (txState_r == TX_SHIFT && txBit_r == 4'hF);
  wire        txLaunch     = riseEn && txFree && txJob && !slbOn;
  wire        sampleLaunch = txLaunch && sampleDue_r;
  wire        passTake     = txLaunch && !sampleDue_r;
  wire [15:0] adcWord      = mixedSel ? {1'b0, adcSample_r[14:0]} : adcSample_r;
  wire [15:0] txWordSel    = sampleDue_r ? adcWord : passWord_r;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sampleCnt_r <= 16'h0000;
      sampleDue_r <= 1'b0;
    end else begin
      if (riseEn) begin
        sampleCnt_r <= sampleTick ? 16'h0000 : sampleCnt_r + 16'h0001;
      end
      if (sampleTick) begin
        sampleDue_r <= 1'b1;
      end else if (sampleLaunch) begin
        sampleDue_r <= 1'b0;
      end
    end
  end

  // One pass-on slot; a second pass word before launch overwrites the first
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      passPend_r <= 1'b0;
      passWord_r <= 16'h0000;
    end else if (ctrlPass) begin
      passPend_r <= 1'b1;
      passWord_r <= {rxWord_r[15:14], cwAddr - 3'h1, rxWord_r[10:0]};
    end else if (passTake) begin
      passPend_r <= 1'b0;
    end
  end

  // Serial-port loop-back delay line
  logic [`CSP_LOOP_SCLKS-1:0] slbFs_r;
  logic [`CSP_LOOP_SCLKS-1:0] slbDat_r;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      slbFs_r  <= '0;
      slbDat_r <= '0;
    end else if (fallEn) begin
      slbFs_r  <= {slbFs_r[`CSP_LOOP_SCLKS-2:0], ifsBit};
      slbDat_r <= {slbDat_r[`CSP_LOOP_SCLKS-2:0], sdiBit};
    end
  end

  // Transmitter: outputs change at serial clock rise, host samples at fall
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      txState_r <= TX_IDLE;
      txSr_r    <= 16'h0000;
      txBit_r   <= 4'h0;
      outFs_r   <= 1'b0;
      outData_r <= 1'b0;
    end else if (riseEn) begin
      if (slbOn) begin
        outFs_r   <= slbFs_r[`CSP_LOOP_SCLKS-1];
        outData_r <= slbDat_r[`CSP_LOOP_SCLKS-1];
        txState_r <= TX_IDLE;
      end else begin
        unique case (txState_r)
          TX_IDLE: begin
            outData_r <= 1'b0;
            outFs_r   <= txLaunch;
            if (txLaunch) begin
              txSr_r    <= txWordSel;
              txState_r <= TX_SYNC;
            end
          end
          TX_SYNC: begin
            outFs_r   <= 1'b0;
            outData_r <= txSr_r[15];
            txSr_r    <= {txSr_r[14:0], 1'b0};
            txBit_r   <= 4'h1;
            txState_r <= TX_SHIFT;
          end
          TX_SHIFT: begin
            outData_r <= txSr_r[15];
            txSr_r    <= {txSr_r[14:0], 1'b0};
            txBit_r   <= txBit_r + 4'h1;
            outFs_r   <= 1'b0;
            if (txBit_r == 4'hF) begin
              if (txLaunch) begin
                outFs_r   <= 1'b1;
                txSr_r    <= txWordSel;
                txState_r <= TX_SYNC;
              end else begin
                txState_r <= TX_IDLE;
              end
            end
          end
          default: txState_r <= TX_IDLE;
        endcase
      end
    end
  end
  assign serialDataOut   = outData_r;
  assign outputFrameSync = outFs_r;

  // Cascade frame counting and DAC load
  logic [2:0]  frameCnt_r;
  logic [15:0] dac_r;
  always_ff @(posedge mclk) begin
    if (regClr) begin
      frameCnt_r <= 3'h0;
    end else if (dataWord) begin
      frameCnt_r <= (frameCnt_r == cascadeCnt) ? 3'h0 : frameCnt_r + 3'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (regClr) begin
      dac_r <= 16'h0000;
    end else if (dlbOn) begin
      if (sampleLaunch) begin
        dac_r <= adcSample_r;
      end
    end else if (dataWord && frameCnt_r == cascadeCnt) begin
      dac_r <= mixedSel ? {rxWord_r[14:0], 1'b0} : rxWord_r;
    end
  end
  assign dacData = dac_r;

  // AXI4-Lite slave
  logic [7:0] memRd;
  csp_ctrl_regs #(.AW(3), .DW(8)) u_regs (
    .clk   (mclk),
    .clr   (regClr),
    .we    (ctrlHere),
    .waddr (cwReg),
    .wdata (ctrlWdata),
    .raddr (s_axi_araddr[4:2]),
    .rdata (memRd)
  );

  function automatic logic [1:0] respFor(input logic [7:0] a);
    respFor = (a <= `CSP_OFF_DAC && a[1:0] == 2'b00) ? 2'b00 : 2'b10;
  endfunction

  logic       awReady_r;
  logic       wReady_r;
  logic       awHave_r;
  logic       wHave_r;
  logic [7:0] awAddr_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;
  logic       bValid_r;
  logic [1:0] bResp_r;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      awReady_r   <= 1'b1;
      wReady_r    <= 1'b1;
      awHave_r    <= 1'b0;
      wHave_r     <= 1'b0;
      awAddr_r    <= 8'h00;
      wData_r     <= 32'h0000_0000;
      wStrb_r     <= 4'h0;
      bValid_r    <= 1'b0;
      bResp_r     <= 2'b00;
      adcSample_r <= 16'h0000;
    end else begin
      if (s_axi_awvalid && awReady_r) begin
        awAddr_r  <= s_axi_awaddr;
        awHave_r  <= 1'b1;
        awReady_r <= 1'b0;
      end
      if (s_axi_wvalid && wReady_r) begin
        wData_r  <= s_axi_wdata;
        wStrb_r  <= s_axi_wstrb;
        wHave_r  <= 1'b1;
        wReady_r <= 1'b0;
      end
      if (awHave_r && wHave_r && !bValid_r) begin
        bValid_r <= 1'b1;
        bResp_r  <= respFor(awAddr_r);
        if (awAddr_r == `CSP_OFF_ADC) begin
          if (wStrb_r[0]) adcSample_r[7:0]  <= wData_r[7:0];
          if (wStrb_r[1]) adcSample_r[15:8] <= wData_r[15:8];
        end
      end
      if (bValid_r && s_axi_bready) begin
        bValid_r  <= 1'b0;
        awHave_r  <= 1'b0;
        wHave_r   <= 1'b0;
        awReady_r <= 1'b1;
        wReady_r  <= 1'b1;
      end
    end
  end
  assign s_axi_awready = awReady_r;
  assign s_axi_wready  = wReady_r;
  assign s_axi_bvalid  = bValid_r;
  assign s_axi_bresp   = bResp_r;

  logic       arReady_r;
  logic       rPhase_r;
  logic [7:0] rdAddr_r;
  logic       rValid_r;
  logic [31:0] rData_r;
  logic [1:0] rResp_r;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      arReady_r <= 1'b1;
      rPhase_r  <= 1'b0;
      rdAddr_r  <= 8'h00;
      rValid_r  <= 1'b0;
      rData_r   <= 32'h0000_0000;
      rResp_r   <= 2'b00;
    end else begin
      rPhase_r <= 1'b0;
      if (s_axi_arvalid && arReady_r) begin
        arReady_r <= 1'b0;
        rdAddr_r  <= s_axi_araddr;
        rPhase_r  <= 1'b1;
      end
      if (rPhase_r) begin
        rValid_r <= 1'b1;
        rResp_r  <= respFor(rdAddr_r);
        if (respFor(rdAddr_r) != 2'b00) begin
          rData_r <= 32'h0000_0000;
        end else if (rdAddr_r <= `CSP_OFF_CTRL_LAST) begin
          rData_r <= {24'h000000, memRd};
        end else if (rdAddr_r == `CSP_OFF_STATUS) begin
          rData_r <= {24'h000000, frameCnt_r, analogLoop_r, dlbOn, slbOn, mixedSel, dataSel};
        end else if (rdAddr_r == `CSP_OFF_ADC) begin
          rData_r <= {16'h0000, adcSample_r};
        end else begin
          rData_r <= {16'h0000, dac_r};
        end
      end
      if (rValid_r && s_axi_rready) begin
        rValid_r  <= 1'b0;
        arReady_r <= 1'b1;
      end
    end
  end
  assign s_axi_arready = arReady_r;
  assign s_axi_rvalid  = rValid_r;
  assign s_axi_rdata   = rData_r;
  assign s_axi_rresp   = rResp_r;

  // Checks; pulse widths assume the default divider
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence s_fs_hold;
    (outFs_r || slbOn) [*8] ##1 (!outFs_r || slbOn);
  endsequence

  a_sclk_period: assert property ($changed(sclk_r) |=> $stable(sclk_r) [*3] ##1 $changed(sclk_r))
    else $error("serial clock half period wrong");
  a_fs_pulse_len: assert property ($rose(outFs_r) && !slbOn |-> s_fs_hold)
    else $error("frame sync not one serial clock wide");
  a_first_bit_out: assert property (txLaunch |-> ##9 (slbOn || outData_r == $past(txWordSel[15], 9)))
    else $error("first bit not sent after frame sync");
  a_adc_msb_clear: assert property (sampleLaunch && mixedSel |=> !txSr_r[15])
    else $error("mixed mode sample MSB not cleared");
  a_dac_mixed_lsb: assert property (dataWord && mixedSel && !dlbOn && frameCnt_r == cascadeCnt
    |=> dac_r == {$past(rxWord_r[14:0]), 1'b0})
    else $error("mixed mode DAC load wrong");
  a_dlb_copy: assert property (dlbOn && sampleLaunch |=> dac_r == $past(adcSample_r))
    else $error("digital loop-back copy missing");
  a_dlb_sticky: assert property (dlbOn && !mixedSel && !swReset |=> dlbOn)
    else $error("digital loop-back left without mixed mode");
  a_slb_sticky: assert property (slbOn && !mixedSel && !swReset |=> slbOn)
    else $error("serial loop-back left without mixed mode");
  a_alb_gate: assert property (ctrlPower_r[`CSP_BIT_GAINTAP] |=> !analogLoop_r)
    else $error("analog loop-back with gain tap powered");
  a_slb_echo: assert property (slbOn && fallEn && ifsBit && !ctrlHere |-> ##[120:130] (outFs_r || !slbOn))
    else $error("frame sync not echoed in loop-back");
  a_ctrl_pass: assert property (ctrlPass |=> passPend_r && passWord_r[13:11] == $past(cwAddr) - 3'h1)
    else $error("control word not passed on");
endmodule

// [csp_host_model.sv]
// Host serial port model: sends 16-bit frames, captures device output words.
// Assumes the device drives serialClock; decoupled wiring, own input frame sync.
`timescale 1ns/1ps
module csp_host_model (
  input  wire logic        serialClock,
  input  wire logic        serialDataOut,
  input  wire logic        outputFrameSync,
  output logic             serialDataIn,
  output logic             inputFrameSync,
  output logic [15:0]      rxWord,
  output logic [15:0]      rxCount
);
  int rxBits = 0;

  // Lines settled before the device leaves reset
  initial begin
    serialDataIn   = 1'b0;
    inputFrameSync = 1'b0;
    rxWord         = 16'h0000;
    rxCount        = 16'h0000;
  end

  // Paced by the device clock, host makes its own sync
  task automatic send_word(input logic [15:0] w, input int gap);
    @(posedge serialClock);
    inputFrameSync <= 1'b1;
    for (int i = 15; i >= 0; i--) begin
      @(posedge serialClock);
      inputFrameSync <= 1'b0;
      serialDataIn   <= w[i];
    end
    @(posedge serialClock);
    // Released line flips so a stale bit never looks valid
    serialDataIn <= ~w[0];
    repeat (gap) @(posedge serialClock);
  endtask

  // Output frame sync is an input here; last-bit sync restarts
  always @(negedge serialClock) begin
    if (rxBits != 0) begin
      rxWord = {rxWord[14:0], serialDataOut};
      rxBits = rxBits - 1;
      if (rxBits == 0) rxCount = rxCount + 16'h0001;
    end
    if (outputFrameSync === 1'b1) rxBits = 16;
  end
endmodule

// [tb_codec_serial_port_modes_cascade.sv]
// Testbench for the codec serial port: AXI4-Lite tasks plus host frame model.
// Assumes a short sample interval; only wstrb is tied.
`timescale 1ns/1ps
module tb_codec_serial_port_modes_cascade;
  logic        mclk = 1'b0;
  logic        sys_rst, serialClock, serialDataIn, inputFrameSync, serialDataOut, outputFrameSync;
  logic [15:0] dacData, rxWord, rxCount;
  logic        analogLoopbackOn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          errTotal = 0;
  int          checks = 0;
  int          cycles = 0;

  always #10 mclk = ~mclk;

  csp_serial_port #(.SAMPLE_SCLKS(40)) dut (
    .mclk(mclk), .sys_rst(sys_rst), .serialClock(serialClock), .serialDataIn(serialDataIn),
    .inputFrameSync(inputFrameSync), .serialDataOut(serialDataOut), .outputFrameSync(outputFrameSync),
    .dacData(dacData), .analogLoopbackOn(analogLoopbackOn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

  csp_host_model host (
    .serialClock(serialClock), .serialDataOut(serialDataOut), .outputFrameSync(outputFrameSync),
    .serialDataIn(serialDataIn), .inputFrameSync(inputFrameSync), .rxWord(rxWord), .rxCount(rxCount));

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      errTotal++;
    end
  endtask

  task automatic stopTest();
    $display("Comparisons %0d, mismatches %0d", checks, errTotal);
    if (errTotal == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 200);
    s_axi_bready <= 1'b0;
  endtask

  task automatic axiRead(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] resp);
    int n;
    n = 0;
    @(posedge mclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 200);
    s_axi_rready <= 1'b0;
    check("rdata", exp, s_axi_rdata);
    check("rresp", {30'h0, resp}, {30'h0, s_axi_rresp});
  endtask

  // Any word may pass first; look for the expected one
  task automatic waitRx(input logic [15:0] exp);
    logic [15:0] last;
    last = rxCount;
    for (int n = 0; n < 3000; n++) begin
      @(posedge mclk);
      if (rxCount !== last && rxWord === exp) break;
      last = rxCount;
    end
    check("rxWord", {16'h0, exp}, {16'h0, rxWord});
  endtask

  task automatic note(input string s);
    $display("Test %s done", s);
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 40000) begin
      errTotal++;
      stopTest();
    end
  end

  initial begin
    sys_rst = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata  = 32'h0;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    axiRead(8'h20, 32'h0, 2'h0);
    check("dacData", 32'h0, {16'h0, dacData});
    note("reset");
    host.send_word(16'h8003, 2);
    axiRead(8'h20, 32'h3, 2'h0);
    host.send_word(16'h1235, 2);
    check("dacData", 32'h246A, {16'h0, dacData});
    note("mixed");
    host.send_word(16'h8580, 2);
    check("analogLoop", 32'h1, {31'h0, analogLoopbackOn});
    host.send_word(16'h8202, 2);
    check("analogLoop", 32'h0, {31'h0, analogLoopbackOn});
    note("analog");
    host.send_word(16'h8D55, 2);
    waitRx(16'h8555);
    axiRead(8'h14, 32'h80, 2'h0);
    axiWrite(8'h24, 32'h0000FFFF);
    waitRx(16'h7FFF);
    note("passOnAndSample");
    host.send_word(16'h8013, 2);
    host.send_word(16'h0100, 2);
    check("dacData", 32'h246A, {16'h0, dacData});
    host.send_word(16'h0200, 2);
    check("dacData", 32'h0400, {16'h0, dacData});
    note("cascade");
    host.send_word(16'h800B, 2);
    axiWrite(8'h24, 32'h00004321);
    waitRx(16'h4321);
    check("dacData", 32'h4321, {16'h0, dacData});
    host.send_word(16'h8003, 2);
    axiRead(8'h20, 32'h3, 2'h0);
    note("digitalLoop");
    host.send_word(16'h8007, 2);
    host.send_word(16'h5A3C, 0);
    waitRx(16'h5A3C);
    host.send_word(16'h8003, 2);
    axiRead(8'h20, 32'h3, 2'h0);
    note("serialLoop");
    host.send_word(16'h8009, 2);
    host.send_word(16'h8001, 2);
    axiRead(8'h20, 32'h9, 2'h0);
    sys_rst <= 1'b1;
    @(posedge mclk);
    sys_rst <= 1'b0;
    axiRead(8'h20, 32'h0, 2'h0);
    axiRead(8'h2C, 32'h0, 2'h2);
    note("resetAndUnmapped");
    stopTest();
  end
endmodule
